// File: core/fdec_pkg.sv
/*
 * Constants, field layouts and carrier types of the float coprocessor
 * decoder. Assumes a 32-bit classic Wishbone register bus with byte offsets.
 */
package fdec_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CC = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PRED = 8'h0C;
    localparam logic [7:0] OFS_RESP = 8'h10;
    localparam logic [7:0] OFS_OP = 8'h14;
    localparam logic [7:0] OFS_DEC = 8'h18;
    // Control register: own coprocessor ID and unordered trap enable.
    localparam int CTRL_ID_LSB = 0;
    localparam int CTRL_TRAP_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h1;
    // Condition code bits and reset.
    localparam int CC_N = 3;
    localparam int CC_Z = 2;
    localparam int CC_NAN = 0;
    localparam logic [3:0] CC_RST = 4'h0;
    // Status bits.
    localparam int ST_UNORD = 0;
    localparam int ST_SUSP = 1;
    localparam int ST_ILL = 2;
    // Response fields.
    localparam int RSP_TRUE = 0;
    localparam int RSP_EXC = 1;
    localparam int RSP_VEC_LSB = 2;
    localparam int RSP_VALID = 10;
    localparam logic [10:0] RSP_RST = 11'h000;
    // Predicate and decode readback fields.
    localparam int PRED_SIG_BIT = 4;
    localparam int DEC_MATCH_BIT = 19;
    localparam int DEC_LEGAL_BIT = 20;
    // Operation word (bits 31:16) and command word (bits 15:0).
    localparam int OP_LINE_LSB = 28;
    localparam int OP_ID_LSB = 25;
    localparam int OP_TYPE_LSB = 22;
    localparam int OP_MODE_LSB = 19;
    localparam int OP_REG_LSB = 16;
    localparam int CMD_RM_BIT = 14;
    localparam int CMD_SRC_LSB = 10;
    localparam int CMD_DST_LSB = 7;
    localparam logic [3:0] OP_LINE = 4'hF;
    localparam logic [2:0] OP_GEN = 3'b000;
    localparam logic [2:0] OP_SAVE = 3'b100;
    localparam logic [2:0] OP_RESTORE = 3'b101;
    localparam logic [2:0] FMT_BAD = 3'b111;
    // Effective address modes and mode 7 subcodes.
    localparam logic [2:0] EA_DREG = 3'b000;
    localparam logic [2:0] EA_AREG = 3'b001;
    localparam logic [2:0] EA_IND = 3'b010;
    localparam logic [2:0] EA_POST = 3'b011;
    localparam logic [2:0] EA_PRE = 3'b100;
    localparam logic [2:0] EA_DISP = 3'b101;
    localparam logic [2:0] EA_IDX = 3'b110;
    localparam logic [2:0] EA_EXT = 3'b111;
    localparam logic [2:0] EXT_ABS_W = 3'b000;
    localparam logic [2:0] EXT_ABS_L = 3'b001;
    localparam logic [2:0] EXT_PC_D = 3'b010;
    localparam logic [2:0] EXT_PC_X = 3'b011;
    localparam logic [2:0] EXT_IMM = 3'b100;
    // Which addressing class an operation demands.
    typedef enum logic [1:0] {USE_SAVE, USE_RESTORE, USE_DATA} ea_use_e;
    // Decoded fields of an operation and command word pair.
    typedef struct packed {
        logic [2:0] cp_id;
        logic [2:0] op_type;
        logic [2:0] ea_mode;
        logic [2:0] ea_reg;
        logic rm;
        logic [2:0] src_spec;
        logic [2:0] dest_reg;
    } op_fields_s;
endpackage : fdec_pkg

// File: core/fdec_ea_check.sv
/*
 * Effective address legality check for one operation class.
 * Purely combinational; the caller registers whatever it derives.
 */
`timescale 1ns/1ps
`default_nettype none
module fdec_ea_check (
    // Operation class and address field.
    input wire fdec_pkg::ea_use_e use_i,
    input wire logic [2:0] mode_i,
    input wire logic [2:0] reg_i,
    // Verdict.
    output logic legal_o
);
    import fdec_pkg::*;
    logic ctrl;
    logic alt;
    logic data;

    // Classify the mode; undefined mode 7 subcodes fall in no class.
    always_comb begin
        ctrl = 1'b0;
        alt = 1'b0;
        data = 1'b0;
        case (mode_i)
            EA_DREG: begin
                alt = 1'b1;
                data = 1'b1;
            end
            EA_AREG: alt = 1'b1;
            EA_POST, EA_PRE: begin
                alt = 1'b1;
                data = 1'b1;
            end
            EA_IND, EA_DISP, EA_IDX: begin
                ctrl = 1'b1;
                alt = 1'b1;
                data = 1'b1;
            end
            default: begin
                ctrl = (reg_i <= EXT_PC_X);
                alt = (reg_i == EXT_ABS_W) || (reg_i == EXT_ABS_L);
                data = (reg_i <= EXT_IMM);
            end
        endcase
    end

    // Per-operation restriction of the allowed modes.
    always_comb begin
        case (use_i)
            USE_SAVE: legal_o = (ctrl && alt) || (mode_i == EA_PRE);
            USE_RESTORE: legal_o = ctrl || (mode_i == EA_POST);
            USE_DATA: legal_o = data;
            default: legal_o = 1'b0;
        endcase
    end
endmodule : fdec_ea_check
`default_nettype wire

// File: core/fdec_pred_eval.sv
/*
 * Evaluates a conditional predicate against the condition codes.
 * Combinational; the top bit of the predicate is never looked at.
 */
`timescale 1ns/1ps
`default_nettype none
module fdec_pred_eval (
    // Predicate and codes.
    input wire logic [5:0] pred_i,
    input wire logic [3:0] cc_i,
    // Verdict.
    output logic true_o,
    output logic signaling_o
);
    import fdec_pkg::*;
    logic n;
    logic z;
    logic u;

    assign n = cc_i[CC_N];
    assign z = cc_i[CC_Z];
    assign u = cc_i[CC_NAN];
    assign signaling_o = pred_i[PRED_SIG_BIT];

    // Signaling tests share the relation of their non-signaling twin.
    always_comb begin
        case (pred_i[3:0])
            4'h0: true_o = 1'b0;
            4'h1: true_o = z;
            4'h2: true_o = !(u || z || n);
            4'h3: true_o = z || !(u || n);
            4'h4: true_o = n && !(u || z);
            4'h5: true_o = z || (n && !u);
            4'h6: true_o = !(u || z);
            4'h7: true_o = !u;
            4'h8: true_o = u;
            4'h9: true_o = u || z;
            4'hA: true_o = u || !(n || z);
            4'hB: true_o = u || z || !n;
            4'hC: true_o = u || (n && !z);
            4'hD: true_o = u || z || n;
            4'hE: true_o = !z;
            default: true_o = 1'b1;
        endcase
    end
endmodule : fdec_pred_eval
`default_nettype wire

// File: core/fdec_top.sv
/*
 * Float coprocessor decode front end: predicate evaluation, state save and
 * restore words and common instruction fields, reached over classic
 * Wishbone. Assumes one synchronous clock domain and a master that holds
 * each request until it sees ack.
 */
`timescale 1ns/1ps
`default_nettype none
module fdec_top #(
    // Vector returned with the unordered trap; value is arbitrary.
    parameter logic [7:0] UNORD_VECTOR = 8'h01
) (
    // System.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Engine control pulses.
    output logic suspend_o,
    output logic restore_o,
    output logic illegal_o,
    output logic op_valid_o,
    // Operand routing of the last accepted general operation.
    output logic external_operand_o,
    output logic [2:0] source_float_register_o,
    output logic [2:0] operand_format_o,
    output logic [2:0] dest_float_register_o
);
    import fdec_pkg::*;

    typedef enum logic {ENG_RUN, ENG_SUSPENDED} engine_e;

    engine_e engine;
    logic access;
    logic wr;
    logic rd;
    logic [3:0] ctrl;
    logic [3:0] cc;
    logic unord;
    logic ill_seen;
    logic [10:0] resp;
    logic [18:0] dec_fields;
    logic dec_match;
    logic dec_legal;
    op_fields_s f;
    logic pred_wr;
    logic op_wr;
    logic pred_true;
    logic pred_sig;
    logic unord_hit;
    ea_use_e ea_use;
    logic ea_legal;
    logic fline;
    logic id_match;
    logic is_save;
    logic is_restore;
    logic is_gen;
    logic fmt_bad;
    logic op_illegal;
    logic op_ok;
    logic [31:0] next_rdata;

    // A request is served once; ack itself masks the held request.
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i;
    assign rd = access && !wb_we_i;
    assign pred_wr = wr && (wb_adr_i == OFS_PRED) && wb_sel_i[0];
    assign op_wr = wr && (wb_adr_i == OFS_OP) && (wb_sel_i == 4'hF);

    // Split the written word pair into its fields.
    assign f.cp_id = wb_dat_i[OP_ID_LSB +: 3];
    assign f.op_type = wb_dat_i[OP_TYPE_LSB +: 3];
    assign f.ea_mode = wb_dat_i[OP_MODE_LSB +: 3];
    assign f.ea_reg = wb_dat_i[OP_REG_LSB +: 3];
    assign f.rm = wb_dat_i[CMD_RM_BIT];
    assign f.src_spec = wb_dat_i[CMD_SRC_LSB +: 3];
    assign f.dest_reg = wb_dat_i[CMD_DST_LSB +: 3];

    assign fline = (wb_dat_i[OP_LINE_LSB +: 4] == OP_LINE);
    assign id_match = fline && (f.cp_id == ctrl[CTRL_ID_LSB +: 3]);

    assign is_save = (f.op_type == OP_SAVE);
    assign is_restore = (f.op_type == OP_RESTORE);
    assign is_gen = (f.op_type == OP_GEN);
    assign fmt_bad = f.rm && (f.src_spec == FMT_BAD);

    // Pick the address class that the operation demands.
    always_comb begin
        if (is_save) begin
            ea_use = USE_SAVE;
        end else if (is_restore) begin
            ea_use = USE_RESTORE;
        end else begin
            ea_use = USE_DATA;
        end
    end

    fdec_ea_check u_ea_check (
        .use_i(ea_use),
        .mode_i(f.ea_mode),
        .reg_i(f.ea_reg),
        .legal_o(ea_legal)
    );

    always_comb begin
        op_illegal = 1'b0;
        if (is_save || is_restore) begin
            op_illegal = !ea_legal;
        end else if (is_gen && f.rm) begin
            op_illegal = !ea_legal || fmt_bad;
        end
    end
    assign op_ok = op_wr && id_match && !op_illegal;

    fdec_pred_eval u_pred_eval (
        .pred_i(wb_dat_i[5:0]),
        .cc_i(cc),
        .true_o(pred_true),
        .signaling_o(pred_sig)
    );

    assign unord_hit = pred_wr && pred_sig && cc[CC_NAN];

    // Bus handshake: ack one cycle after the request, for one cycle.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    // Read multiplexer; unmapped offsets read as zero but still ack.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CTRL: next_rdata[3:0] = ctrl;
            OFS_CC: next_rdata[3:0] = cc;
            OFS_STATUS: begin
                next_rdata[ST_UNORD] = unord;
                next_rdata[ST_SUSP] = (engine == ENG_SUSPENDED);
                next_rdata[ST_ILL] = ill_seen;
            end
            OFS_RESP: next_rdata[10:0] = resp;
            OFS_DEC: begin
                next_rdata[18:0] = dec_fields;
                next_rdata[DEC_MATCH_BIT] = dec_match;
                next_rdata[DEC_LEGAL_BIT] = dec_legal;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is registered and presented together with ack.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            wb_dat_o <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl <= CTRL_RST;
        end else if (wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[3:0];
        end
    end

    // Condition codes are loaded by the arithmetic side through the bus.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cc <= CC_RST;
        end else if (wr && (wb_adr_i == OFS_CC) && wb_sel_i[0]) begin
            cc <= wb_dat_i[3:0];
        end
    end

    // sticky unordered flag
    // A new hit in the clearing cycle wins, so no event is lost.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            unord <= 1'b0;
        end else if (unord_hit) begin
            unord <= 1'b1;
        end else if (wr && (wb_adr_i == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_UNORD]) begin
            unord <= 1'b0;
        end
    end

    // Sticky illegal-operation flag, set wins over clear as well.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ill_seen <= 1'b0;
        end else if (op_wr && id_match && op_illegal) begin
            ill_seen <= 1'b1;
        end else if (wr && (wb_adr_i == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_ILL]) begin
            ill_seen <= 1'b0;
        end
    end

    // one path for both branch sizes
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            resp <= RSP_RST;
        end else if (pred_wr) begin
            resp <= RSP_RST;
            resp[RSP_VALID] <= 1'b1;
            if (unord_hit && ctrl[CTRL_TRAP_BIT]) begin
                resp[RSP_EXC] <= 1'b1;
                resp[RSP_VEC_LSB +: 8] <= UNORD_VECTOR;
            end else begin
                resp[RSP_TRUE] <= pred_true;
            end
        end
    end

    // restore loads at once
    // Save and restore act in the same edge whatever the engine is doing.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            engine <= ENG_RUN;
        end else if (op_ok && is_save) begin
            engine <= ENG_SUSPENDED;
        end else if (op_ok && is_restore) begin
            engine <= ENG_RUN;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            suspend_o <= 1'b0;
            restore_o <= 1'b0;
            illegal_o <= 1'b0;
            op_valid_o <= 1'b0;
        end else begin
            suspend_o <= op_ok && is_save;
            restore_o <= op_ok && is_restore;
            illegal_o <= op_wr && id_match && op_illegal;
            op_valid_o <= op_ok && is_gen;
        end
    end

    // Decode readback keeps every written word, matched or not.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            dec_fields <= 19'h0_0000;
            dec_match <= 1'b0;
            dec_legal <= 1'b0;
        end else if (op_wr) begin
            dec_fields <= f;
            dec_match <= id_match;
            dec_legal <= !op_illegal;
        end
    end

    // destination float register
    // Routing only moves on a legal general operation, so a rejected
    // word never disturbs an operation already being set up.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            external_operand_o <= 1'b0;
            source_float_register_o <= 3'h0;
            operand_format_o <= 3'h0;
            dest_float_register_o <= 3'h0;
        end else if (op_ok && is_gen) begin
            external_operand_o <= f.rm;
            source_float_register_o <= f.rm ? 3'h0 : f.src_spec;
            operand_format_o <= f.rm ? f.src_spec : 3'h0;
            dest_float_register_o <= f.dest_reg;
        end
    end

    // Bus acknowledges last one cycle only.
    ack_single_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle.");

    // A predicate write produces a valid response one edge later.
    pred_answer_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        pred_wr |=> wb_ack_o && resp[RSP_VALID])
        else $error("Predicate write gave no response.");

    // The true test answers a fixed true value, any top bit.
    pred_fixed_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        pred_wr && !unord_hit && (wb_dat_i[3:0] == 4'hF) |=> resp[RSP_TRUE] && !resp[RSP_EXC])
        else $error("True test did not answer true.");

    // Signaling test with NaN sets the flag and traps when enabled.
    unord_trap_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        unord_hit && ctrl[CTRL_TRAP_BIT]
        |=> unord && resp[RSP_EXC] && (resp[RSP_VEC_LSB +: 8] == UNORD_VECTOR))
        else $error("Unordered trap not raised.");

    // Non-signaling tests never touch the unordered flag.
    nonsig_quiet_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        pred_wr && !wb_dat_i[PRED_SIG_BIT] && !unord |=> !unord && !resp[RSP_EXC])
        else $error("Non-signaling test raised unordered.");

    // A legal save suspends on the very next edge.
    save_suspend_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        op_wr && id_match && is_save && (f.ea_mode == EA_PRE)
        |=> suspend_o && (engine == ENG_SUSPENDED) ##1 !suspend_o)
        else $error("Save did not suspend at once.");

    // A legal restore returns the engine to run at once.
    restore_load_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        op_wr && id_match && is_restore && (f.ea_mode == EA_POST)
        |=> restore_o && (engine == ENG_RUN))
        else $error("Restore did not load at once.");

    // Foreign IDs cause no engine pulse; only the decode readback records them.
    foreign_id_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        op_wr && !id_match |=> !suspend_o && !restore_o && !illegal_o && !op_valid_o)
        else $error("Acted on a foreign coprocessor ID.");

    // Save through a data register is disallowed and flagged.
    save_bad_mode_a : assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        op_wr && id_match && is_save && (f.ea_mode == EA_DREG)
        |=> illegal_o && !suspend_o ##1 ill_seen)
        else $error("Disallowed save mode not flagged.");
endmodule : fdec_top
`default_nettype wire

// File: sim/fdec_host_model.sv
/*
 * Main processor side of the coprocessor interface: a classic Wishbone
 * master that runs one register access at a time on request.
 * Assumes it shares the decoder's clock and that the slave answers with ack.
 */
`timescale 1ns/1ps
`default_nettype none
module fdec_host_model (
    // Clock.
    input wire logic clk_sys_i,
    // Wishbone master.
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i
);
    // The bus is idle from time zero.
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end

    // One classic cycle held until ack is seen; released address and data lines show the
    // inverse of their last value so stale data is never mistaken for live.
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= wd;
        do begin
            @(posedge clk_sys_i);
        end while (wb_ack_i !== 1'b1);
        rd = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_adr_o <= ~adr;
        wb_dat_o <= ~wd;
    endtask : xfer

    // branch target calculation
    // The offset counts bytes from the displacement word, so a short
    // displacement must be sign extended before it is added.
    function automatic logic [31:0] branch_target(input logic [31:0] disp_adr, input logic [15:0] disp);
        return disp_adr + {{16{disp[15]}}, disp};
    endfunction : branch_target
endmodule : fdec_host_model
`default_nettype wire

// File: sim/fdec_top_tb.sv
/*
 * Self-checking bench of the float coprocessor decoder.
 * Assumes the host model as bus master and counts engine pulses per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module fdec_top_tb;
    import fdec_pkg::*;
    localparam logic [7:0] VEC = 8'h5A;
    localparam logic [31:0] S_P = 32'h0100_0000;
    localparam logic [31:0] R_P = 32'h0001_0000;
    localparam logic [31:0] I_P = 32'h0000_0100;
    localparam logic [31:0] V_P = 32'h0000_0001;
    localparam logic [3:0] CC_TAB [4] = '{4'h4, 4'h0, 4'h8, 4'h1};
    logic clk_sys_i;
    logic reset_i;
    logic wb_cyc, wb_stb, wb_we, wb_ack, ext_op, ok;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd_val, exp_p, dp_v;
    logic suspend, restore, illegal, op_valid;
    logic [2:0] src_reg, fmt, dst_reg, mv, rv;
    logic [31:0] pulses = 32'h0;
    int error_cnt = 0;
    int cmp_count = 0;

    fdec_top #(.UNORD_VECTOR(VEC)) u_fdec_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat), .suspend_o(suspend),
        .restore_o(restore), .illegal_o(illegal), .op_valid_o(op_valid), .external_operand_o(ext_op),
        .source_float_register_o(src_reg), .operand_format_o(fmt), .dest_float_register_o(dst_reg));
    fdec_host_model u_fdec_host_model (.clk_sys_i(clk_sys_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
        .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
        .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat));

    // Clock of 4 ns.
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // One byte counter per pulse output, so a stuck pulse shows as extra counts.
    always @(posedge clk_sys_i) begin
        pulses <= pulses + {7'h0, suspend === 1'b1, 7'h0, restore === 1'b1,
                            7'h0, illegal === 1'b1, 7'h0, op_valid === 1'b1};
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Accesses end at the falling edge so pulse counters have settled.
    task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel = 4'h1);
        u_fdec_host_model.xfer(1'b1, adr, sel, d, rd_val);
        @(negedge clk_sys_i);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        u_fdec_host_model.xfer(1'b0, adr, 4'hF, 32'h0, rd_val);
        @(negedge clk_sys_i);
        chk(rd_val, exp);
    endtask : rd

    task automatic op(input logic [2:0] id, typ, md, rg, input logic [15:0] cmd, input logic [31:0] dp);
        wr(OFS_OP, {OP_LINE, id, typ, md, rg, cmd}, 4'hF);
        exp_p = exp_p + dp;
        chk(pulses, exp_p);
    endtask : op

    task automatic route(input logic [9:0] e);
        chk({22'h0, ext_op, src_reg, fmt, dst_reg}, {22'h0, e});
    endtask : route

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // Tests run in order after an eight cycle reset.
    initial begin
        reset_i = 1'b1;
        exp_p = 32'h0;
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(OFS_CTRL, {28'h0, CTRL_RST});
        rd(OFS_CC, {28'h0, CC_RST});
        rd(OFS_STATUS, 32'h0);
        rd(OFS_RESP, 32'h0);
        rd(OFS_DEC, 32'h0);
        wr(8'h1C, 32'hFFFF_FFFF, 4'hF);
        rd(8'h1C, 32'h0);
        rd(OFS_PRED, 32'h0);
        route(10'h0);
        $display("Test reset values done");
        // Every predicate, top bit included, against each condition class.
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CC, {28'h0, CC_TAB[c]});
            for (int p = 0; p < 64; p++) begin
                wr(OFS_PRED, 32'(p));
                rd(OFS_RESP, {21'h0, 1'b1, 8'h0, 1'b0, p[c]});
            end
        end
        rd(OFS_STATUS, 32'h1);
        wr(OFS_STATUS, 32'h1);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h9);
        wr(OFS_CC, 32'h1);
        wr(OFS_PRED, 32'h30);
        rd(OFS_RESP, {21'h0, 1'b1, VEC, 1'b1, 1'b0});
        wr(OFS_PRED, 32'h08);
        rd(OFS_RESP, {21'h0, 1'b1, 8'h0, 1'b0, 1'b1});
        chk(u_fdec_host_model.branch_target(32'h0000_1000, 16'hFFFC), 32'h0000_0FFC);
        wr(OFS_CTRL, 32'h1);
        $display("Test predicates done");
        // Save and restore over every address mode and mode seven subcode.
        for (int t = 0; t < 2; t++) begin
            for (int i = 0; i < 15; i++) begin
                mv = (i < 7) ? 3'(i) : EA_EXT;
                rv = (i < 7) ? 3'h3 : 3'(i - 7);
                if (t == 0) ok = (mv inside {EA_IND, EA_PRE, EA_DISP, EA_IDX}) || (mv == EA_EXT && rv <= EXT_ABS_L);
                else ok = (mv inside {EA_IND, EA_POST, EA_DISP, EA_IDX}) || (mv == EA_EXT && rv <= EXT_PC_X);
                dp_v = ok ? (t ? R_P : S_P) : I_P;
                op(3'h1, t ? OP_RESTORE : OP_SAVE, mv, rv, 16'h0, dp_v);
            end
        end
        rd(OFS_DEC, {11'h0, 1'b0, 1'b1, 3'h1, OP_RESTORE, EA_EXT, 3'h7, 7'h0});
        $display("Test save and restore done");
        // Each own ID is answered and its neighbour ignored.
        for (int id = 0; id < 8; id++) begin
            wr(OFS_CTRL, 32'(id));
            op(3'(id), OP_SAVE, EA_IND, 3'h0, 16'h0, S_P);
            op(3'(id ^ 1), OP_SAVE, EA_IND, 3'h0, 16'h0, 32'h0);
        end
        wr(OFS_CTRL, 32'h1);
        // The ID matches here, so only the wrong line field keeps it quiet.
        wr(OFS_OP, 32'hE310_0000, 4'hF);
        chk(pulses, exp_p);
        rd(OFS_STATUS, 32'h7);
        $display("Test coprocessor ID done");
        // General operations: register source, every format, bad modes.
        op(3'h1, OP_GEN, EA_DREG, 3'h0, {3'h0, 3'h5, 3'h6, 7'h0}, V_P);
        route({1'b0, 3'h5, 3'h0, 3'h6});
        for (int f = 0; f < 8; f++) begin
            op(3'h1, OP_GEN, EA_IND, 3'h0, {3'h2, 3'(f), 3'(f ^ 3), 7'h0}, f < 7 ? V_P : I_P);
            route({1'b1, 3'h0, f < 7 ? 3'(f) : 3'h6, f < 7 ? 3'(f ^ 3) : 3'h5});
        end
        op(3'h1, OP_GEN, EA_AREG, 3'h0, {3'h2, 3'h1, 3'h1, 7'h0}, I_P);
        op(3'h1, OP_GEN, EA_EXT, 3'h5, {3'h2, 3'h1, 3'h1, 7'h0}, I_P);
        op(3'h1, OP_GEN, EA_AREG, 3'h0, {3'h0, 3'h2, 3'h7, 7'h0}, V_P);
        route({1'b0, 3'h2, 3'h0, 3'h7});
        $display("Test general operations done");
        print_verdict();
    end

    // Watchdog well beyond the roughly two thousand cycles the tests need.
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        error_cnt++;
        print_verdict();
    end
endmodule : fdec_top_tb
`default_nettype wire
